// ===== hdl/cdf_pkg.sv
package cdf_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] CDF_CTRL_OFS = 8'h00;
  localparam logic [7:0] CDF_HPA_OFS = 8'h04;
  localparam logic [7:0] CDF_HPB_OFS = 8'h08;
  localparam logic [7:0] CDF_EQ_OFS = 8'h0c;
  localparam logic [7:0] CDF_IVOL_OFS = 8'h24;
  localparam logic [7:0] CDF_OVOL_OFS = 8'h28;
  localparam logic [7:0] CDF_STAT_OFS = 8'h2c;
  localparam int CDF_EQ_NUM = 6;
  // Control word; field order is the bit layout, lowest field at bit 0.
  typedef struct packed {
    logic beep_to_speaker;
    logic beep_to_analog_out;
    logic beep_power_enable;
    logic mic_differential_select;
    logic [1:0] zero_cross_timeout_sel;
    logic playback_level_ctrl_enable;
    logic record_level_ctrl_enable;
    logic prog_filter_power;
    logic input_converter_power;
    logic band_two_enable;
    logic band_one_enable;
    logic highpass_enable;
    logic input_highpass_enable;
    logic filter_to_serial_out;
    logic filter_to_converter_out;
    logic recording_path_select;
  } cdf_ctrl_s;
  localparam int CDF_CTRL_W = 17;
  localparam cdf_ctrl_s CDF_CTRL_RST = 17'h00005;
  // ----------------------------------------------------------------
  // Arithmetic constants
  // ----------------------------------------------------------------
  localparam int COEF_FRAC = 13;
  localparam logic [7:0] VOL_UNITY = 8'h91;
  localparam logic [7:0] VOL_MUTE = 8'h00;
  localparam logic [8:0] VOL_EXP_BIAS = 9'h00f;
  localparam int VOL_SHIFT = 24;
  localparam logic [10:0] ZC_BASE = 11'h080;
  // Gain of 0.375 dB steps within one 6 dB octave, unity is 16384.
  localparam logic [15:0] VOL_MANT [16] = '{16'h4000, 16'h42d3, 16'h45c6, 16'h48d9,
    16'h4c10, 16'h4f6c, 16'h52ed, 16'h5695, 16'h5a67, 16'h5e64, 16'h628e, 16'h66e8,
    16'h6b71, 16'h702f, 16'h7522, 16'h7a4d};
endpackage : cdf_pkg

// ===== hdl/cdf_path.sv
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module cdf_path
  import cdf_pkg::*;
(
  input wire logic clk_i, // 10 MHz system clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic psel_i, // APB select.
  input wire logic penable_i, // APB access phase.
  input wire logic pwrite_i, // APB write.
  input wire logic [7:0] paddr_i, // APB byte address.
  input wire logic [31:0] pwdata_i, // APB write data.
  output logic [31:0] prdata_o, // APB read data.
  output logic pready_o, // APB ready.
  output logic pslverr_o, // APB error on unmapped address.
  input wire logic sample_tick_i, // One pulse per sample period.
  input wire logic [15:0] conv_sample_i, // Converter-side sample.
  input wire logic [15:0] serial_sample_i, // Serial-side sample.
  output logic [15:0] conv_sample_o, // Sample to the output converter.
  output logic [15:0] serial_sample_o, // Sample to the serial port.
  output logic sample_valid_o // Pulse when outputs update.
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic signed [15:0] sat(input logic signed [47:0] v);
    if (v > 48'sd32767) sat = 16'sh7fff;
    else if (v < -48'sd32768) sat = 16'sh8000;
    else sat = v[15:0];
  endfunction : sat
  // First-order high-pass: y = A(x - x1) + B y1.
  function automatic logic signed [15:0] hp_step(input logic signed [15:0] x, xp, yp,
                                                 input logic [13:0] a, b);
    logic signed [47:0] acc;
    acc = 48'($signed(a)) * (48'(x) - 48'(xp)) + 48'($signed(b)) * 48'(yp);
    hp_step = sat(acc >>> COEF_FRAC);
  endfunction : hp_step
  // Band-pass part of a band: p = A(x - x2) + B p1 + C p2.
  function automatic logic signed [15:0] eq_step(input logic signed [15:0] x, x2, p1, p2,
                                                 input logic [15:0] a, b, c);
    logic signed [47:0] acc;
    acc = 48'($signed(a)) * (48'(x) - 48'(x2)) + 48'($signed(b)) * 48'(p1)
        + 48'($signed(c)) * 48'(p2);
    eq_step = sat(acc >>> COEF_FRAC);
  endfunction : eq_step
  function automatic logic signed [15:0] vol_apply(input logic signed [15:0] x,
                                                   input logic [7:0] code);
    logic [8:0] e;
    logic signed [47:0] p;
    e = {1'b0, code} + VOL_EXP_BIAS;
    p = 48'(x) * 48'($signed({1'b0, VOL_MANT[e[3:0]]}));
    p = p <<< e[8:4];
    vol_apply = (code == VOL_MUTE) ? 16'sh0000 : sat(p >>> VOL_SHIFT);
  endfunction : vol_apply

  // ----------------------------------------------------------------
  // Register file and APB slave
  // ----------------------------------------------------------------
  cdf_ctrl_s ctrl, next_ctrl;
  logic [13:0] hp_a, hp_b, next_hp_a, next_hp_b;
  logic [15:0] eq_coef [CDF_EQ_NUM];
  logic [15:0] next_eq_coef [CDF_EQ_NUM];
  logic [7:0] vol_code [2];
  logic [7:0] next_vol_code [2];
  logic [7:0] vol_act [2];
  logic [7:0] next_vol_act [2];
  logic vol_pend [2];
  logic next_vol_pend [2];
  logic [10:0] zc_cnt [2];
  logic [10:0] next_zc_cnt [2];
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, acc_done, wr, hit, vol_wr;
  logic [10:0] zc_limit;

  assign acc_done = psel_i & penable_i & pready_o;
  assign wr = acc_done & pwrite_i;
  assign zc_limit = ZC_BASE << ctrl.zero_cross_timeout_sel;

  // Decode, register writes and the registered read answer; one wait state.
  always_comb begin
    next_ctrl = ctrl;
    next_hp_a = hp_a;
    next_hp_b = hp_b;
    next_eq_coef = eq_coef;
    next_prdata = prdata_o;
    next_pready = psel_i & penable_i & ~pready_o;
    hit = 1'b1;
    unique case (paddr_i)
      CDF_CTRL_OFS: next_prdata = 32'(ctrl);
      CDF_HPA_OFS: next_prdata = 32'(hp_a);
      CDF_HPB_OFS: next_prdata = 32'(hp_b);
      CDF_IVOL_OFS: next_prdata = 32'(vol_code[0]);
      CDF_OVOL_OFS: next_prdata = 32'(vol_code[1]);
      CDF_STAT_OFS: next_prdata = {14'h0000, vol_pend[1], vol_pend[0], vol_act[1], vol_act[0]};
      default: begin
        hit = 1'b0;
        next_prdata = 32'h0000_0000;
        for (int k = 0; k < CDF_EQ_NUM; k++) begin
          if (paddr_i == CDF_EQ_OFS + 8'(4 * k)) begin
            hit = 1'b1;
            next_prdata = 32'(eq_coef[k]);
          end
        end
      end
    endcase
    next_pslverr = next_pready & ~hit;
    if (wr && hit) begin
      unique case (paddr_i)
        CDF_CTRL_OFS: next_ctrl = pwdata_i[CDF_CTRL_W-1:0];
        CDF_HPA_OFS: next_hp_a = pwdata_i[13:0];
        CDF_HPB_OFS: next_hp_b = pwdata_i[13:0];
        default: begin
          for (int k = 0; k < CDF_EQ_NUM; k++) begin
            if (paddr_i == CDF_EQ_OFS + 8'(4 * k)) next_eq_coef[k] = pwdata_i[15:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CDF_CTRL_RST;
      hp_a <= '0;
      hp_b <= '0;
      for (int k = 0; k < CDF_EQ_NUM; k++) eq_coef[k] <= '0;
      prdata_o <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      hp_a <= next_hp_a;
      hp_b <= next_hp_b;
      eq_coef <= next_eq_coef;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  logic signed [15:0] hx [4], hy [4], ex1 [2], ex2 [2], ep1 [2], ep2 [2];
  logic signed [15:0] next_hx [4], next_hy [4], next_ex1 [2], next_ex2 [2];
  logic signed [15:0] next_ep1 [2], next_ep2 [2];
  logic signed [15:0] st [7];
  logic signed [15:0] bp;
  logic on [4];
  logic prev_sign, next_prev_sign, zc;
  logic [7:0] gain;
  logic [15:0] next_conv, next_serial;

  assign on[0] = ctrl.recording_path_select & ctrl.input_highpass_enable
               & ctrl.input_converter_power;
  assign on[1] = ctrl.highpass_enable & ctrl.prog_filter_power;
  assign on[2] = ctrl.band_one_enable & ctrl.prog_filter_power;
  assign on[3] = ctrl.band_two_enable & ctrl.prog_filter_power;
  assign zc = st[5][15] != prev_sign;

  always_comb begin
    if (ctrl.recording_path_select && !ctrl.record_level_ctrl_enable) gain = vol_act[0];
    else if (!ctrl.recording_path_select && !ctrl.playback_level_ctrl_enable) gain = vol_act[1];
    else gain = VOL_UNITY;
  end

  // Whole chain settles within one clock; states move only on a sample tick.
  // A disabled stage clears its history so it restarts clean when enabled.
  always_comb begin
    next_hx = hx;
    next_hy = hy;
    next_ex1 = ex1;
    next_ex2 = ex2;
    next_ep1 = ep1;
    next_ep2 = ep2;
    bp = '0;
    st[0] = ctrl.recording_path_select ? conv_sample_i : serial_sample_i;
    for (int s = 0; s < 4; s++) begin
      st[s+1] = on[s/2] ? hp_step(st[s], hx[s], hy[s], hp_a, hp_b) : st[s];
      next_hx[s] = on[s/2] ? st[s] : 16'sh0000;
      next_hy[s] = on[s/2] ? st[s+1] : 16'sh0000;
    end
    for (int b = 0; b < 2; b++) begin
      bp = eq_step(st[4+b], ex2[b], ep1[b], ep2[b], eq_coef[3*b], eq_coef[3*b+1],
                   eq_coef[3*b+2]);
      st[5+b] = on[2+b] ? sat(48'(st[4+b]) + 48'(bp)) : st[4+b];
      next_ex1[b] = on[2+b] ? st[4+b] : 16'sh0000;
      next_ex2[b] = on[2+b] ? ex1[b] : 16'sh0000;
      next_ep1[b] = on[2+b] ? bp : 16'sh0000;
      next_ep2[b] = on[2+b] ? ep1[b] : 16'sh0000;
    end
    st[5] = st[6];
    st[6] = vol_apply(st[5], gain);
    next_prev_sign = st[5][15];
    next_conv = ctrl.filter_to_converter_out ? st[6] : conv_sample_o;
    next_serial = ctrl.filter_to_serial_out ? st[6] : serial_sample_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int s = 0; s < 4; s++) begin
        hx[s] <= '0;
        hy[s] <= '0;
      end
      for (int b = 0; b < 2; b++) begin
        ex1[b] <= '0;
        ex2[b] <= '0;
        ep1[b] <= '0;
        ep2[b] <= '0;
      end
      prev_sign <= 1'b0;
      conv_sample_o <= '0;
      serial_sample_o <= '0;
      sample_valid_o <= 1'b0;
    end else begin
      sample_valid_o <= sample_tick_i;
      if (sample_tick_i) begin
        hx <= next_hx;
        hy <= next_hy;
        ex1 <= next_ex1;
        ex2 <= next_ex2;
        ep1 <= next_ep1;
        ep2 <= next_ep2;
        prev_sign <= next_prev_sign;
        conv_sample_o <= next_conv;
        serial_sample_o <= next_serial;
      end
    end
  end

  // ----------------------------------------------------------------
  // Volume codes and zero-cross update, index 0 input, 1 output
  // ----------------------------------------------------------------
  always_comb begin
    next_vol_code = vol_code;
    next_vol_act = vol_act;
    next_vol_pend = vol_pend;
    next_zc_cnt = zc_cnt;
    vol_wr = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (sample_tick_i && vol_pend[i]) begin
        if (zc || (zc_cnt[i] + 11'd1 >= zc_limit)) begin
          next_vol_act[i] = vol_code[i];
          next_vol_pend[i] = 1'b0;
          next_zc_cnt[i] = '0;
        end else begin
          next_zc_cnt[i] = zc_cnt[i] + 11'd1;
        end
      end
      // restart only on change; a write wins over a same-cycle apply.
      vol_wr = wr && paddr_i == (i == 0 ? CDF_IVOL_OFS : CDF_OVOL_OFS);
      if (vol_wr && pwdata_i[7:0] != vol_code[i]) begin
        next_vol_code[i] = pwdata_i[7:0];
        next_vol_pend[i] = 1'b1;
        next_zc_cnt[i] = '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 2; i++) begin
        vol_code[i] <= VOL_UNITY;
        vol_act[i] <= VOL_UNITY;
        vol_pend[i] <= 1'b0;
        zc_cnt[i] <= '0;
      end
    end else begin
      vol_code <= next_vol_code;
      vol_act <= next_vol_act;
      vol_pend <= next_vol_pend;
      zc_cnt <= next_zc_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ROUTE_HOLD: assert property (sample_tick_i && !ctrl.filter_to_converter_out |=>
    $stable(conv_sample_o)) else $error("Converter output moved while not routed.");
  AST_UNITY_PASS: assert property (sample_tick_i && !on[0] && !on[1] && !on[2] && !on[3]
    && gain == VOL_UNITY && ctrl.filter_to_serial_out |=> serial_sample_o == $past(st[0]))
    else $error("Bypassed path is not 0dB.");
  AST_HP_CLEAR: assert property (sample_tick_i && !on[1] |=> hx[2] == 0 && hy[3] == 0)
    else $error("Disabled high-pass kept history.");
  AST_EQ_BYPASS: assert property (!on[2] && !on[3] |-> st[5] == st[4])
    else $error("Disabled band altered data.");
  AST_MUTE: assert property (sample_tick_i && gain == VOL_MUTE && ctrl.filter_to_serial_out
    |=> serial_sample_o == 16'h0000) else $error("Mute code passed signal.");
  AST_VOL_WAIT: assert property (sample_tick_i && vol_pend[0] && !zc && !vol_wr
    && zc_cnt[0] + 11'd1 < zc_limit |=> $stable(vol_act[0])) else $error("Volume applied early.");
  AST_VOL_TIMEOUT: assert property (sample_tick_i && vol_pend[1] && !wr
    && zc_cnt[1] + 11'd1 == zc_limit |=> vol_act[1] == vol_code[1] && !vol_pend[1])
    else $error("Volume not applied at timeout.");
  AST_RESTART: assert property (wr && paddr_i == CDF_IVOL_OFS
    && pwdata_i[7:0] != vol_code[0] |=> zc_cnt[0] == 0 && vol_pend[0])
    else $error("Different code did not restart counter.");
  AST_APB_READY: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("Access phase not answered in one wait state.");
endmodule : cdf_path
`default_nettype wire

// ===== sim/cdf_host.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Host side: APB master and sample source
// ----------------------------------------------------------------
module cdf_host (
  input wire logic clk_i, // System clock.
  input wire logic [31:0] prdata_i, // APB read data.
  input wire logic pready_i, // APB ready.
  input wire logic pslverr_i, // APB error.
  output logic psel_o, // APB select.
  output logic penable_o, // APB access phase.
  output logic pwrite_o, // APB direction.
  output logic [7:0] paddr_o, // APB address.
  output logic [31:0] pwdata_o, // APB write data.
  output logic tick_o, // Sample period pulse.
  output logic [15:0] conv_o, // Converter-side sample.
  output logic [15:0] serial_o // Serial-side sample.
);
  // Idle bus and no tick from time zero.
  initial begin
    {psel_o, penable_o, pwrite_o, tick_o} = 4'h0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
    conv_o = 16'h0;
    serial_o = 16'h0;
  end
  // One transfer; the request stands until ready is seen at an edge.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    // No cycle count is assumed here; only the bench watchdog may end a hung access.
    while (pready_i !== 1'b1) @(posedge clk_i);
    q = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer
  // One sample; inputs are scrambled after the tick so stale data never looks valid.
  task automatic put(input logic [15:0] c, input logic [15:0] s);
    @(posedge clk_i);
    tick_o <= 1'b1;
    conv_o <= c;
    serial_o <= s;
    @(posedge clk_i);
    tick_o <= 1'b0;
    conv_o <= ~c;
    serial_o <= ~s;
  endtask : put
endmodule : cdf_host
`default_nettype wire

// ===== sim/codec_digital_path_filter_volume_bench.sv
`timescale 1ns/100ps
`default_nettype none
module codec_digital_path_filter_volume_bench;
  import cdf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, tick, valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cur;
  logic [15:0] cin, sin, cout, sout, so, co, x, y, ps, pc;
  logic [2:0] modes [3] = '{3'b101, 3'b010, 3'b111};
  logic [7:0] codes [6] = '{8'h01, 8'h81, 8'ha1, 8'hf1, 8'h00, 8'h91};
  logic [31:0] fcfg [6] = '{32'h115, 32'h8d, 32'h15, 32'h125, 32'h145, 32'h165};
  int fstep [6] = '{0, 0, 0, 100, 100, 100};
  int fdelta [6] = '{-1000, -1000, 0, 200, -100, 100};
  int fail_count = 0;
  int checked = 0;
  int seed = 95;
  // Clock of 100 ns period.
  always #50 clk_i = ~clk_i;
  cdf_host host_i (.clk_i(clk_i), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .tick_o(tick), .conv_o(cin), .serial_o(sin));
  cdf_path cdf_path_i (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sample_tick_i(tick), .conv_sample_i(cin),
    .serial_sample_i(sin), .conv_sample_o(cout), .serial_sample_o(sout),
    .sample_valid_o(valid));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    host_i.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic e;
    host_i.xfer(1'b0, a, 32'h0, q, e);
    chk("read data", exp, q);
    chk("read error", {31'h0, experr}, {31'h0, e});
  endtask : rd
  // Sends one sample and captures both outputs once they have settled.
  task automatic smp(input logic [15:0] c, input logic [15:0] s);
    host_i.put(c, s);
    @(negedge clk_i);
    chk("sample valid", 32'h1, {31'h0, valid});
    so = sout;
    co = cout;
  endtask : smp
  // Gain in whole 6 dB octaves (16 codes each), saturated to 16 bits.
  function automatic logic [15:0] vol(input logic [7:0] c, input logic signed [15:0] v);
    int r;
    r = (c == 8'h00) ? 0 : int'(v);
    if (c > 8'h91) r = r <<< ((c - 8'h91) >> 4);
    else r = r >>> ((8'h91 - c) >> 4);
    if (r > 32767) r = 32767;
    if (r < -32768) r = -32768;
    return r[15:0];
  endfunction : vol
  // Hang guard, well beyond the expected run of some 5000 cycles.
  initial begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CDF_CTRL_OFS, 32'h5, 1'b0);
    rd(CDF_IVOL_OFS, 32'h91, 1'b0);
    rd(CDF_STAT_OFS, 32'h9191, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    $display("test reset done");
    {ps, pc} = 32'h0;
    foreach (modes[i]) repeat (4) begin
      x = 16'($random(seed));
      y = 16'($random(seed));
      wr(CDF_CTRL_OFS, {29'h0, modes[i]});
      smp(x, y);
      if (modes[i][2]) ps = modes[i][0] ? x : y;
      if (modes[i][1]) pc = modes[i][0] ? x : y;
      chk("serial out", {16'h0, ps}, {16'h0, so});
      chk("converter out", {16'h0, pc}, {16'h0, co});
    end
    $display("test paths done");
    wr(CDF_CTRL_OFS, 32'h5);
    smp(16'hfc00, 16'h0);
    foreach (codes[i]) begin
      wr(CDF_IVOL_OFS, {24'h0, codes[i]});
      smp(16'd1024, 16'h0);
      smp(16'hfc00, 16'h0);
      chk("input volume", {16'h0, vol(codes[i], 16'hfc00)}, {16'h0, so});
      rd(CDF_STAT_OFS, {16'h0, 8'h91, codes[i]}, 1'b0);
    end
    $display("test gain done");
    smp(16'd100, 16'h0);
    for (int s = 0; s < 4; s++) begin
      cur = s[0] ? 32'h91 : 32'h81;
      wr(CDF_CTRL_OFS, 32'h5 | (s << 11));
      wr(CDF_IVOL_OFS, cur);
      repeat (60) smp(16'd100, 16'h0);
      wr(CDF_IVOL_OFS, cur);
      repeat ((128 << s) - 61) smp(16'd100, 16'h0);
      rd(CDF_STAT_OFS, 32'h19100 | (cur ^ 32'h10), 1'b0);
      smp(16'd100, 16'h0);
      rd(CDF_STAT_OFS, 32'h9100 | cur, 1'b0);
    end
    wr(CDF_CTRL_OFS, 32'h5);
    wr(CDF_IVOL_OFS, 32'h81);
    repeat (60) smp(16'd100, 16'h0);
    wr(CDF_IVOL_OFS, 32'h91);
    repeat (127) smp(16'd100, 16'h0);
    rd(CDF_STAT_OFS, 32'h19191, 1'b0);
    smp(16'd100, 16'h0);
    rd(CDF_STAT_OFS, 32'h9191, 1'b0);
    $display("test timeout done");
    wr(CDF_HPA_OFS, 32'h2000);
    wr(CDF_EQ_OFS, 32'h2000);
    wr(CDF_EQ_OFS + 8'h0c, 32'hf000);
    foreach (fcfg[i]) begin
      wr(CDF_CTRL_OFS, fcfg[i]);
      for (int k = 0; k < 8; k++) begin
        smp(16'(1000 + fstep[i] * k), 16'h0);
        if (k >= 5) chk("filter", 32'(16'(1000 + fstep[i] * k + fdelta[i])), {16'h0, so});
      end
      wr(CDF_CTRL_OFS, 32'h5);
    end
    $display("test filters done");
    wr(CDF_CTRL_OFS, 32'h2);
    wr(CDF_OVOL_OFS, 32'h81);
    smp(16'h0, 16'hfe70);
    smp(16'h0, 16'd400);
    smp(16'h0, 16'hfe70);
    chk("output volume", {16'h0, vol(8'h81, 16'hfe70)}, {16'h0, co});
    rd(CDF_STAT_OFS, 32'h8191, 1'b0);
    // Level control on bypasses the manual output volume.
    wr(CDF_CTRL_OFS, 32'h402);
    smp(16'h0, 16'hfe70);
    chk("level control bypass", 32'hfe70, {16'h0, co});
    // A steady sign never crosses zero, so only the timeout applies the new code.
    wr(CDF_OVOL_OFS, 32'h91);
    repeat (127) smp(16'h0, 16'hfe70);
    rd(CDF_STAT_OFS, 32'h28191, 1'b0);
    smp(16'h0, 16'hfe70);
    rd(CDF_STAT_OFS, 32'h9191, 1'b0);
    $display("test playback volume done");
    complete_run();
  end
endmodule : codec_digital_path_filter_volume_bench
`default_nettype wire
